// >>> core/servo_feedback_status_logic.sv
// Servo drive feedback, step counting, PWM rate and status logic
`timescale 1ns/1ps
`default_nettype none

module servo_feedback_status_logic
  import servo_status_pkg::*;
#(
  parameter int          RAW_SAMPLE_CYCLES = RAW_PERIOD_CYC,
  parameter logic [3:0]  LOGIC_HW_REV      = 4'h1,
  parameter logic [23:0] LOGICWARE_VER     = 24'h030041,
  // Arbitrary set of defined model codes, one bit per code
  parameter logic [31:0] MODEL_VALID_MASK  = 32'h0000007F
) (
  input  wire  logic                     clk,
  input  wire  logic                     srst,
  // Pins: opto inputs are high while current flows in the diode
  input  wire  logic                     hallLineU,
  input  wire  logic                     hallLineV,
  input  wire  logic                     hallLineW,
  input  wire  logic                     stepOptoCurrent,
  input  wire  logic                     dirOptoCurrent,
  input  wire  logic                     enableOptoCurrent,
  input  wire  logic [3:0]               dipSwitchPins,
  input  wire  logic [3:0]               rotarySwitchPins,
  input  wire  logic [4:0]               modelCodePins,
  // Same-domain feedback from the encoder receiver and current loop
  input  wire  logic                     encSampleValid,
  input  wire  logic [ANGLE_W-1:0]       encAngle,
  input  wire  logic [TURN_W-1:0]        encTurns,
  input  wire  logic [2:0]               encFaultCode,
  input  wire  logic [CUR_W-1:0]         motorCurrentMag,
  input  wire  logic [CUR_W-1:0]         drivePeakCurrent,
  input  wire  logic [FREQ_W-1:0]        commFreqCentiHz,
  input  wire  logic signed [TEMP_W-1:0] heatsinkTemperature,
  input  wire  logic signed [TEMP_W-1:0] heatsinkTripTemperature,
  input  wire  logic                     stepDirSelected,
  input  wire  logic                     softwarePowerPermitWr,
  input  wire  logic                     softwarePowerPermitData,
  input  wire  logic                     softwareFaultClear,
  // Status
  output logic [2:0]                     hallState,
  output logic                           stepPulseInputState,
  output logic                           enableInputState,
  output logic [STEP_W-1:0]              stepCount,
  output logic                           reducedSwitchingRateFlag,
  output logic                           softwarePowerPermit,
  output logic                           powerStageOn,
  output logic [ANGLE_W-1:0]             shaftAnglePosition,
  output logic signed [TURN_W-1:0]       shaftTurnCount,
  output logic signed [SPEED_W-1:0]      rawShaftSpeed,
  output logic signed [SPEED_W-1:0]      filteredShaftSpeed,
  output logic [3:0]                     logicHwRevision,
  output logic [23:0]                    logicwareVersion,
  output logic [4:0]                     modelCode,
  output logic                           modelConfigError,
  output logic [3:0]                     dipSwitchSetting,
  output logic [3:0]                     rotarySwitchSetting,
  output logic                           encoderSensorError,
  output logic                           encoderMultiTurnFault,
  output logic                           heatsinkOverTempFault
);

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: three stages, a change counts when 2 and 3 agree

  logic [PIN_W-1:0] pinRaw;
  logic [PIN_W-1:0] pinS1_q;
  logic [PIN_W-1:0] pinS2_q;
  logic [PIN_W-1:0] pinS3_q;
  logic [PIN_W-1:0] pin_q;
  logic [PIN_W-1:0] pinPrev_q;

  assign pinRaw = {2'h0, modelCodePins, rotarySwitchPins, dipSwitchPins,
                   enableOptoCurrent, dirOptoCurrent, stepOptoCurrent,
                   hallLineW, hallLineV, hallLineU};

  genvar gi;
  generate
    for (gi = 0; gi < PIN_W; gi++) begin : g_sync
      always_ff @(posedge clk) begin
        if (srst) begin
          pinS1_q[gi]   <= 1'b0;
          pinS2_q[gi]   <= 1'b0;
          pinS3_q[gi]   <= 1'b0;
          pin_q[gi]     <= 1'b0;
          pinPrev_q[gi] <= 1'b0;
        end else begin
          pinS1_q[gi] <= pinRaw[gi];
          pinS2_q[gi] <= pinS1_q[gi];
          pinS3_q[gi] <= pinS2_q[gi];
          if (pinS2_q[gi] == pinS3_q[gi]) begin
            pin_q[gi] <= pinS3_q[gi];
          end
          pinPrev_q[gi] <= pin_q[gi];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Hall, opto and switch read-back

  always_ff @(posedge clk) begin
    if (srst) begin
      hallState           <= 3'h0;
      stepPulseInputState <= 1'b1;
      enableInputState    <= 1'b1;
      dipSwitchSetting    <= 4'h0;
      rotarySwitchSetting <= 4'h0;
      modelCode           <= 5'h00;
      modelConfigError    <= 1'b0;
    end else begin
      hallState[HALL_W_BIT] <= pin_q[PIN_HALL_W];
      hallState[HALL_V_BIT] <= pin_q[PIN_HALL_V];
      hallState[HALL_U_BIT] <= pin_q[PIN_HALL_U];
      stepPulseInputState   <= ~pin_q[PIN_STEP];
      enableInputState      <= ~pin_q[PIN_ENABLE];
      // An open contact pulls its pin high
      dipSwitchSetting <= pin_q[PIN_DIP_LO +: 4];
      // Codes past 9 are contact bounce between detents; keep the last
      if (pin_q[PIN_ROT_LO +: 4] <= ROT_MAX) begin
        rotarySwitchSetting <= pin_q[PIN_ROT_LO +: 4];
      end
      modelCode        <= pin_q[PIN_MOD_LO +: 5];
      modelConfigError <= ~MODEL_VALID_MASK[pin_q[PIN_MOD_LO +: 5]];
    end
  end

  chk_hall_weighting: assert property (
    hallState == $past({pin_q[PIN_HALL_W], pin_q[PIN_HALL_V],
                        pin_q[PIN_HALL_U]}))
    else $error("hall value does not follow W V U weighting");

  chk_rotary_range: assert property (rotarySwitchSetting <= ROT_MAX)
    else $error("rotary setting above nine");

  ////////////////////////////////////////////////////////////////////////////
  // Step counting

  logic stepEdge;
  assign stepEdge = pinPrev_q[PIN_STEP] & ~pin_q[PIN_STEP];

  always_ff @(posedge clk) begin
    if (srst) begin
      stepCount <= '0;
    end else if (stepDirSelected && stepEdge) begin
      // No current on direction counts up
      if (pin_q[PIN_DIR]) begin
        stepCount <= stepCount - 1'b1;
      end else begin
        stepCount <= stepCount + 1'b1;
      end
    end
  end

  sequence s_step_release;
    stepDirSelected && pinPrev_q[PIN_STEP] && !pin_q[PIN_STEP];
  endsequence

  chk_step_count: assert property (
    s_step_release |=> stepCount != $past(stepCount))
    else $error("step release did not count");

  chk_step_quiet: assert property (
    !(pinPrev_q[PIN_STEP] && !pin_q[PIN_STEP]) |=> $stable(stepCount))
    else $error("step count moved without a release edge");

  ////////////////////////////////////////////////////////////////////////////
  // PWM rate with hysteresis

  logic [CUR_W+6:0] curScaled_q;
  logic [CUR_W+6:0] hiLimit_q;
  logic [CUR_W+6:0] loLimit_q;
  pwm_rate_t        rate_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      curScaled_q <= '0;
      hiLimit_q   <= '0;
      loLimit_q   <= '0;
    end else begin
      curScaled_q <= motorCurrentMag * PCT_DIV;
      hiLimit_q   <= drivePeakCurrent * CUR_HI_PCT;
      loLimit_q   <= drivePeakCurrent * CUR_LO_PCT;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rate_q <= RATE_BASE;
    end else begin
      unique case (rate_q)
        RATE_BASE: begin
          if (curScaled_q > hiLimit_q && commFreqCentiHz < FREQ_LO_CHZ) begin
            rate_q <= RATE_HALF;
          end
        end
        RATE_HALF: begin
          if (curScaled_q < loLimit_q || commFreqCentiHz > FREQ_HI_CHZ) begin
            rate_q <= RATE_BASE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      reducedSwitchingRateFlag <= 1'b0;
    end else begin
      reducedSwitchingRateFlag <= (rate_q == RATE_HALF);
    end
  end

  chk_pwm_drop: assert property (
    rate_q == RATE_BASE && curScaled_q > hiLimit_q
      && commFreqCentiHz < FREQ_LO_CHZ |=> ##1 reducedSwitchingRateFlag)
    else $error("pwm rate did not drop to half base");

  chk_pwm_return: assert property (
    rate_q == RATE_HALF && commFreqCentiHz > FREQ_HI_CHZ
      |=> ##1 !reducedSwitchingRateFlag)
    else $error("pwm rate did not return to base");

  ////////////////////////////////////////////////////////////////////////////
  // Power enable, latched heat sink fault and encoder fault flags

  always_ff @(posedge clk) begin
    if (srst) begin
      softwarePowerPermit <= PERMIT_RST;
    end else if (softwarePowerPermitWr) begin
      softwarePowerPermit <= softwarePowerPermitData;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      heatsinkOverTempFault <= 1'b0;
    end else if (heatsinkTemperature >= heatsinkTripTemperature) begin
      heatsinkOverTempFault <= 1'b1;
    end else if (softwareFaultClear) begin
      heatsinkOverTempFault <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      encoderSensorError    <= 1'b0;
      encoderMultiTurnFault <= 1'b0;
    end else begin
      encoderSensorError    <= (encFaultCode == ENC_SENSOR_ERR);
      encoderMultiTurnFault <= (encFaultCode == ENC_MTURN_ERR);
    end
  end

  // A latched fault also holds the power stage off until cleared
  always_ff @(posedge clk) begin
    if (srst) begin
      powerStageOn <= 1'b0;
    end else begin
      powerStageOn <= pin_q[PIN_ENABLE] && softwarePowerPermit
                      && !heatsinkOverTempFault;
    end
  end

  chk_power_gate: assert property (
    powerStageOn |-> $past(pin_q[PIN_ENABLE]) && $past(softwarePowerPermit))
    else $error("power on without both enables");

  chk_permit_off: assert property (
    softwarePowerPermitWr && !softwarePowerPermitData
      |=> ##1 !powerStageOn)
    else $error("permit write of zero left power on");

  chk_heatsink_trip: assert property (
    heatsinkTemperature >= heatsinkTripTemperature |=> heatsinkOverTempFault)
    else $error("heat sink fault not raised at trip");

  chk_fault_clear: assert property (
    softwareFaultClear && heatsinkTemperature < heatsinkTripTemperature
      |=> !heatsinkOverTempFault)
    else $error("fault clear did not clear latch");

  ////////////////////////////////////////////////////////////////////////////
  // Position capture and speed

  logic [ANGLE_W-1:0] angle_q;
  logic [ANGLE_W-1:0] rawRef_q;
  logic [ANGLE_W-1:0] filtRef_q;
  logic [ANGLE_W-1:0] rawDiff;
  logic [ANGLE_W-1:0] filtDiff;
  logic [31:0]        rawTimer_q;
  logic [FILT_SHIFT-1:0] rawIdx_q;
  logic               rawTick;
  logic               filtTick;

  assign rawTick  = (rawTimer_q == 32'(RAW_SAMPLE_CYCLES - 1));
  assign filtTick = rawTick && (rawIdx_q == FILT_SHIFT'(FILT_SAMPLES - 1));
  assign rawDiff  = angle_q - rawRef_q;
  assign filtDiff = angle_q - filtRef_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      angle_q            <= '0;
      shaftAnglePosition <= '0;
      shaftTurnCount     <= '0;
    end else if (encSampleValid) begin
      // Upper 16 bits are counts, low 8 bits the fraction
      angle_q            <= encAngle;
      shaftAnglePosition <= encAngle;
      shaftTurnCount     <= encTurns;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rawTimer_q <= '0;
      rawIdx_q   <= '0;
    end else if (rawTick) begin
      rawTimer_q <= '0;
      rawIdx_q   <= rawIdx_q + 1'b1;
    end else begin
      rawTimer_q <= rawTimer_q + 1'b1;
    end
  end

  // Wrapping 24-bit differences give the right sign across zero angle
  always_ff @(posedge clk) begin
    if (srst) begin
      rawRef_q      <= '0;
      rawShaftSpeed <= '0;
    end else if (rawTick) begin
      rawRef_q      <= angle_q;
      rawShaftSpeed <= SPEED_W'($signed(rawDiff) >>> RAW_SHIFT);
    end
  end

  // Span of 512 raw periods divided by 512 equals their mean
  always_ff @(posedge clk) begin
    if (srst) begin
      filtRef_q          <= '0;
      filteredShaftSpeed <= '0;
    end else if (filtTick) begin
      filtRef_q          <= angle_q;
      filteredShaftSpeed <= SPEED_W'($signed(filtDiff)
                                     >>> (RAW_SHIFT + FILT_SHIFT));
    end
  end

  chk_filt_hold: assert property (
    !filtTick |=> $stable(filteredShaftSpeed))
    else $error("filtered speed changed between updates");

  chk_filt_value: assert property (
    filtTick |=> filteredShaftSpeed == SPEED_W'($signed($past(filtDiff))
                                                 >>> (RAW_SHIFT + FILT_SHIFT)))
    else $error("filtered speed not from sample span");

  chk_angle_capture: assert property (
    encSampleValid |=> shaftAnglePosition == $past(encAngle)
                       && shaftTurnCount == $past(encTurns))
    else $error("angle or turn count not captured");

  ////////////////////////////////////////////////////////////////////////////
  // Identity

  always_ff @(posedge clk) begin
    if (srst) begin
      logicHwRevision  <= 4'h0;
      logicwareVersion <= 24'h000000;
    end else begin
      logicHwRevision  <= LOGIC_HW_REV;
      logicwareVersion <= LOGICWARE_VER;
    end
  end

endmodule : servo_feedback_status_logic

`default_nettype wire

// >>> inc/servo_status_pkg.sv
// Constants shared by the servo feedback and status logic
package servo_status_pkg;
  // Clock and time base
  localparam int CLK_PERIOD_PS     = 8000;
  localparam longint FILT_PERIOD_PS = 64'd26210000000; // 26.21 ms
  localparam int FILT_SAMPLES      = 512;
  localparam int FILT_SHIFT        = 9;
  localparam int FILT_PERIOD_CYC   = int'(FILT_PERIOD_PS / CLK_PERIOD_PS);
  localparam int RAW_PERIOD_CYC    = FILT_PERIOD_CYC / FILT_SAMPLES;
  // 0.5588 rpm per step equals 8 angle counts per raw sample
  localparam int RAW_SHIFT         = 3;

  // Widths
  localparam int ANGLE_W  = 24;
  localparam int TURN_W   = 12;
  localparam int SPEED_W  = 16;
  localparam int CUR_W    = 16;
  localparam int FREQ_W   = 16;
  localparam int TEMP_W   = 12;
  localparam int STEP_W   = 32;
  localparam int SYNC_N   = 3;
  localparam int PIN_W    = 21;

  // Synchronised pin vector layout
  localparam int PIN_HALL_U  = 0;
  localparam int PIN_HALL_V  = 1;
  localparam int PIN_HALL_W  = 2;
  localparam int PIN_STEP    = 3;
  localparam int PIN_DIR     = 4;
  localparam int PIN_ENABLE  = 5;
  localparam int PIN_DIP_LO  = 6;
  localparam int PIN_ROT_LO  = 10;
  localparam int PIN_MOD_LO  = 14;
  localparam int PIN_SPARE   = 19;

  // Hall weights
  localparam int HALL_W_BIT = 2;
  localparam int HALL_V_BIT = 1;
  localparam int HALL_U_BIT = 0;

  // PWM switch thresholds, current in hundredths of peak, freq in cHz
  localparam logic [6:0]  CUR_HI_PCT  = 7'h35; // 53 %
  localparam logic [6:0]  CUR_LO_PCT  = 7'h20; // 32 %
  localparam logic [6:0]  PCT_DIV     = 7'h64; // 100
  localparam logic [FREQ_W-1:0] FREQ_LO_CHZ = 16'h0122; // 2.90 Hz
  localparam logic [FREQ_W-1:0] FREQ_HI_CHZ = 16'h01DD; // 4.77 Hz

  // Encoder detail fault codes
  localparam logic [2:0] ENC_SENSOR_ERR = 3'h1;
  localparam logic [2:0] ENC_MTURN_ERR  = 3'h3;

  localparam logic [3:0] ROT_MAX = 4'h9;

  // Reset values
  localparam logic PERMIT_RST = 1'h1;

  typedef enum logic {RATE_BASE, RATE_HALF} pwm_rate_t;
endpackage : servo_status_pkg

// >>> testbench/servo_far_side_model.sv
// Far-side model: hall sensors, step source and position encoder
`timescale 1ns/1ps
`default_nettype none
module servo_far_side_model
  import servo_status_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               srst,
  input  wire logic [2:0]         hallCmd,
  input  wire logic               stepCmd,
  input  wire logic               dirCmd,
  input  wire logic [ANGLE_W-1:0] angleStep,
  input  wire logic [TURN_W-1:0]  turnsCmd,
  input  wire logic [2:0]         faultCmd,
  output logic                    hallLineU,
  output logic                    hallLineV,
  output logic                    hallLineW,
  output logic                    stepOptoCurrent,
  output logic                    dirOptoCurrent,
  output logic                    encSampleValid,
  output logic [ANGLE_W-1:0]      encAngle,
  output logic [TURN_W-1:0]       encTurns,
  output logic [2:0]              encFaultCode
);
  ////////////////////////////////////////////////////////////////////////
  // Sensor and opto lines are plain levels, never released
  assign {hallLineW, hallLineV, hallLineU} = hallCmd;
  assign stepOptoCurrent = stepCmd;
  assign dirOptoCurrent  = dirCmd;
  assign encTurns        = turnsCmd;
  assign encFaultCode    = faultCmd;
  ////////////////////////////////////////////////////////////////////////
  // Encoder reports every cycle so speed equals angleStep per cycle
  always_ff @(posedge clk) begin
    encSampleValid <= !srst;
    encAngle       <= srst ? '0 : encAngle + angleStep;
  end
endmodule : servo_far_side_model
`default_nettype wire

// >>> testbench/servo_feedback_status_logic_tb.sv
// Self-checking bench for the servo feedback and status logic
`timescale 1ns/1ps
`default_nettype none
module servo_feedback_status_logic_tb
  import servo_status_pkg::*;
();
  localparam logic [31:0] VALID = 32'h0000007F;
  localparam logic [15:0] PWM_CUR [9] = '{16'h0258, 16'h0190, 16'h0136,
    16'h0212, 16'h021C, 16'h021C, 16'h021C, 16'h021C, 16'h021C};
  localparam logic [15:0] PWM_FRQ [9] = '{16'h00C8, 16'h00C8, 16'h00C8,
    16'h00C8, 16'h00C8, 16'h01E0, 16'h012C, 16'h0121, 16'h01DD};
  localparam logic [0:8]  PWM_EXP = 9'h193;
  logic                      clk, srst, stepDirSelected, enableOptoCurrent;
  logic                      softwarePowerPermitWr, softwarePowerPermitData;
  logic                      softwareFaultClear, stepCmd, dirCmd;
  logic [2:0]                hallCmd, faultCmd, hallState;
  logic [3:0]                dipSwitchPins, rotarySwitchPins, expRot;
  logic [4:0]                modelCodePins, modelCode;
  logic [ANGLE_W-1:0]        angleStep, shaftAnglePosition;
  logic [TURN_W-1:0]         turnsCmd;
  logic [CUR_W-1:0]          motorCurrentMag, drivePeakCurrent;
  logic [FREQ_W-1:0]         commFreqCentiHz;
  logic signed [TEMP_W-1:0]  heatsinkTemperature, heatsinkTripTemperature;
  wire                       hallLineU, hallLineV, hallLineW, encSampleValid;
  wire                       stepOptoCurrent, dirOptoCurrent;
  wire  [ANGLE_W-1:0]        encAngle;
  wire  [TURN_W-1:0]         encTurns;
  wire  [2:0]                encFaultCode;
  logic                      stepPulseInputState, enableInputState;
  logic [STEP_W-1:0]         stepCount, expSteps;
  logic                      reducedSwitchingRateFlag, softwarePowerPermit;
  logic                      powerStageOn, modelConfigError;
  logic signed [TURN_W-1:0]  shaftTurnCount;
  logic signed [SPEED_W-1:0] rawShaftSpeed, filteredShaftSpeed, prevF;
  logic [3:0]                logicHwRevision, dipSwitchSetting;
  logic [3:0]                rotarySwitchSetting;
  logic [23:0]               logicwareVersion;
  logic                      encoderSensorError, encoderMultiTurnFault;
  logic                      heatsinkOverTempFault;
  logic [31:0]               rnd;
  int                        failCount, checkCount, i, nChg;

  servo_feedback_status_logic #(.RAW_SAMPLE_CYCLES(4),
    .MODEL_VALID_MASK(VALID)) u_servo_feedback_status_logic (.*);
  servo_far_side_model u_servo_far_side_model (.*);

  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end

  function automatic logic [31:0] lfsrNext(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsrNext

  // Inputs move 1 ns after the edge so no race with the design's flops
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp) begin
      failCount++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic giveVerdict();
    $display("checks=%0d mismatches=%0d", checkCount, failCount);
    if (failCount == 0 && checkCount > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : giveVerdict

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (30000) @(posedge clk);
    failCount++;
    giveVerdict();
  end

  initial begin
    {enableOptoCurrent, softwarePowerPermitWr, softwarePowerPermitData} = '0;
    {softwareFaultClear, stepCmd, dirCmd, hallCmd, faultCmd} = '0;
    {dipSwitchPins, rotarySwitchPins, modelCodePins, angleStep} = '0;
    {turnsCmd, motorCurrentMag, commFreqCentiHz} = '0;
    stepDirSelected = 1'h1;
    srst = 1'h1;
    drivePeakCurrent = 16'h03E8;
    heatsinkTripTemperature = 12'h050;
    heatsinkTemperature = 12'h020;
    rnd = 32'h000003ED;
    expSteps = '0;
    expRot = '0;
    cyc(16);
    srst = 1'h0;
    cyc(8);
    chk(stepPulseInputState, 1'h1);
    chk(softwarePowerPermit, 1'h1);
    chk(logicHwRevision, 4'h1);
    chk(logicwareVersion, 24'h030041);
    for (i = 0; i < 8; i++) begin
      hallCmd = i[2:0];
      cyc(8);
      chk(hallState, i);
    end
    for (i = 0; i < 32; i++) begin
      modelCodePins = i[4:0];
      cyc(8);
      chk({modelConfigError, modelCode}, {!VALID[i], i[4:0]});
    end
    // Random switch settings, then a code above nine the switch cannot show
    for (i = 0; i < 9; i++) begin
      rnd = lfsrNext(rnd);
      dipSwitchPins = rnd[3:0];
      rotarySwitchPins = (i == 8) ? 4'hC : rnd[7:4] % 4'hA;
      expRot = (i == 8) ? expRot : rnd[7:4] % 4'hA;
      cyc(8);
      chk(dipSwitchSetting, rnd[3:0]);
      chk(rotarySwitchSetting, expRot);
    end
    for (i = 0; i < 8; i++) begin
      faultCmd = i[2:0];
      cyc(3);
      chk({encoderSensorError, encoderMultiTurnFault}, {i == 1, i == 3});
    end
    for (i = 0; i < 2; i++) begin
      turnsCmd = i ? 12'h7FF : 12'h800;
      cyc(3);
      chk({shaftTurnCount}, {i ? 12'h7FF : 12'h800});
    end
    rnd = lfsrNext(rnd);
    angleStep = rnd[23:0];
    cyc(1);
    angleStep = '0;
    cyc(3);
    chk(shaftAnglePosition, encAngle);
    for (i = 0; i < 6; i++) begin
      rnd = lfsrNext(rnd);
      dirCmd = rnd[0];
      cyc(8);
      stepCmd = 1'h1;
      cyc(8);
      chk(stepCount, expSteps);
      chk(stepPulseInputState, 1'h0);
      stepCmd = 1'h0;
      cyc(8);
      expSteps = rnd[0] ? expSteps - 1 : expSteps + 1;
      chk(stepCount, expSteps);
    end
    for (i = 0; i < 9; i++) begin
      motorCurrentMag = PWM_CUR[i];
      commFreqCentiHz = PWM_FRQ[i];
      cyc(6);
      chk(reducedSwitchingRateFlag, PWM_EXP[i]);
    end
    enableOptoCurrent = 1'h1;
    cyc(8);
    chk(enableInputState, 1'h0);
    chk(powerStageOn, 1'h1);
    for (i = 0; i < 2; i++) begin
      softwarePowerPermitWr = 1'h1;
      softwarePowerPermitData = i[0];
      cyc(1);
      softwarePowerPermitWr = 1'h0;
      cyc(2);
      chk({softwarePowerPermit, powerStageOn}, {2{i[0]}});
    end
    heatsinkTemperature = heatsinkTripTemperature;
    cyc(3);
    chk({heatsinkOverTempFault, powerStageOn}, 2'h2);
    heatsinkTemperature = 12'h020;
    cyc(3);
    chk(heatsinkOverTempFault, 1'h1);
    softwareFaultClear = 1'h1;
    cyc(1);
    softwareFaultClear = 1'h0;
    cyc(3);
    chk({heatsinkOverTempFault, powerStageOn}, 2'h1);
    enableOptoCurrent = 1'h0;
    cyc(8);
    chk(powerStageOn, 1'h0);
    // 16 counts per cycle: 64 per raw tick, 8 after the raw scaling
    angleStep = 24'h000010;
    cyc(6200);
    chk({rawShaftSpeed}, 16'h0008);
    chk({filteredShaftSpeed}, 16'h0008);
    angleStep = '0;
    nChg = 0;
    repeat (4200) begin
      prevF = filteredShaftSpeed;
      cyc(1);
      nChg = (filteredShaftSpeed !== prevF) ? nChg + 1 : nChg;
    end
    chk(nChg >= 1 && nChg <= 2, 1'h1);
    chk({filteredShaftSpeed, rawShaftSpeed}, 32'h0);
    giveVerdict();
  end
endmodule : servo_feedback_status_logic_tb
`default_nettype wire
